// File: verilog/fep_pkg.sv
// shared constants and carrier types for the flash erase/protect controller
package fep_pkg;
    localparam int FEP_FLASH_BYTES = 131072;   // 128 KB array
    localparam int FEP_BLOCK_BYTES = 1024;     // erase granule
    localparam int FEP_REGION_BYTES = 2048;    // protection granule
    localparam int FEP_WORD_BYTES = 4;
    localparam int FEP_ADDR_W = 17;
    localparam int FEP_DATA_W = 32;
    localparam int FEP_BLK_LSB = 10;           // block number field position
    localparam int FEP_REG_LSB = 11;           // region number field position
    localparam int FEP_WORD_LSB = 2;           // word index field position
    localparam int FEP_NUM_WORDS = FEP_FLASH_BYTES / FEP_WORD_BYTES;
    localparam int FEP_NUM_REGIONS = FEP_FLASH_BYTES / FEP_REGION_BYTES;
    localparam int FEP_BLK_WORDS = FEP_BLOCK_BYTES / FEP_WORD_BYTES;
    localparam logic [31:0] FEP_ERASED_WORD = 32'hFFFFFFFF;
    localparam logic FEP_PROT_RESET = 1'b0;    // regions open after reset
    localparam logic [7:0] FEP_ERASE_STEP_CYC = 8'h01;

    typedef enum logic [1:0] {
        FEP_SRC_IFETCH,
        FEP_SRC_DLOAD,
        FEP_SRC_DEBUG
    } fep_src_t;

    typedef enum logic [1:0] {
        FEP_PROT_OPEN,
        FEP_PROT_RDONLY,
        FEP_PROT_XONLY
    } fep_prot_t;

    typedef struct packed {
        logic valid;
        fep_src_t src;
        logic [FEP_ADDR_W-1:0] addr;
    } fep_rd_req_t;

    typedef struct packed {
        logic valid;
        logic erase;                           // 1 erase block, 0 program word
        logic [FEP_ADDR_W-1:0] addr;
        logic [FEP_DATA_W-1:0] data;
    } fep_mod_req_t;
endpackage

// File: verilog/fep_prot_chk.sv
// region lookup and access permission check
`timescale 1ns/1ps
module fep_prot_chk
    import fep_pkg::*;
#(
    parameter int NUM_REGIONS = FEP_NUM_REGIONS
) (
    input wire logic [FEP_ADDR_W-1:0] addr_in,
    input wire fep_src_t src_in,
    input wire logic is_mod_in,
    input wire logic [NUM_REGIONS-1:0] ro_in,
    input wire logic [NUM_REGIONS-1:0] xo_in,
    output logic allow_out
);
    localparam int RW = $clog2(NUM_REGIONS);
    logic [RW-1:0] region;
    logic ro;
    logic xo;

    // region picked by the bits above the 2 KB offset
    assign region = addr_in[FEP_REG_LSB +: RW];
    assign ro = ro_in[region];
    assign xo = xo_in[region];

    // permission decision, made before the array is touched
    always_comb begin
        if (is_mod_in) begin
            allow_out = !(ro || xo);
        end else if (xo) begin
            allow_out = (src_in == FEP_SRC_IFETCH);
        end else begin
            allow_out = 1'b1;
        end
    end
endmodule // fep_prot_chk

// File: verilog/fep_ctrl.sv
// embedded flash controller: single-cycle reads, block erase, region protection
`timescale 1ns/1ps
module fep_ctrl
    import fep_pkg::*;
#(
    parameter int FLASH_BYTES = FEP_FLASH_BYTES,
    parameter int NUM_REGIONS = FEP_NUM_REGIONS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire fep_rd_req_t rd_req_in,
    output logic [FEP_DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic rd_denied_out,
    input wire fep_mod_req_t mod_req_in,
    output logic mod_ready_out,
    output logic mod_done_out,
    output logic mod_denied_out,
    input wire logic [NUM_REGIONS-1:0] prot_ro_in,
    input wire logic [NUM_REGIONS-1:0] prot_xo_in,
    input wire logic prot_load_in,
    input wire logic viol_clr_in,
    output logic viol_out,
    output logic [NUM_REGIONS-1:0] prot_ro_out,
    output logic [NUM_REGIONS-1:0] prot_xo_out
);
    localparam int WORDS = FLASH_BYTES / FEP_WORD_BYTES;
    localparam int WW = $clog2(WORDS);
    localparam int BW = $clog2(FEP_BLK_WORDS);

    // elaboration check: size must match the fixed 17-bit address map
    if (FLASH_BYTES != FEP_FLASH_BYTES || NUM_REGIONS != FEP_NUM_REGIONS) begin : g_bad
        $error("fep_ctrl: unsupported array size");
    end

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ERASE
    } fep_state_t;

    typedef struct packed {
        fep_state_t state;
        logic [WW-1:0] er_base;
        logic [BW-1:0] er_idx;
        logic [FEP_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic rd_denied;
        logic mod_done;
        logic mod_denied;
        logic viol;
        logic [NUM_REGIONS-1:0] ro;
        logic [NUM_REGIONS-1:0] xo;
    } fep_regs_t;

    fep_regs_t s_q;
    fep_regs_t s_d;
    logic [FEP_DATA_W-1:0] mem_q [WORDS];
    logic rd_allow;
    logic mod_allow;
    logic idle;
    logic mod_go;
    logic er_last;

    // word index from a byte address
    function automatic logic [WW-1:0] word_of(input logic [FEP_ADDR_W-1:0] a);
        word_of = a[FEP_WORD_LSB +: WW];
    endfunction

    fep_prot_chk #(.NUM_REGIONS(NUM_REGIONS)) u_rd_chk (
        .addr_in(rd_req_in.addr),
        .src_in(rd_req_in.src),
        .is_mod_in(1'b0),
        .ro_in(s_q.ro),
        .xo_in(s_q.xo),
        .allow_out(rd_allow)
    );

    fep_prot_chk #(.NUM_REGIONS(NUM_REGIONS)) u_mod_chk (
        .addr_in(mod_req_in.addr),
        .src_in(FEP_SRC_DLOAD),
        .is_mod_in(1'b1),
        .ro_in(s_q.ro),
        .xo_in(s_q.xo),
        .allow_out(mod_allow)
    );

    assign idle = (s_q.state == ST_IDLE);
    // erase busy stalls new modify requests; reads still served
    assign mod_ready_out = idle;
    assign mod_go = mod_req_in.valid && idle;
    assign er_last = (s_q.er_idx == BW'(FEP_BLK_WORDS - 1));

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        s_d.rd_denied = 1'b0;
        s_d.mod_done = 1'b0;
        s_d.mod_denied = 1'b0;
        // protection table load, held while busy so a running erase keeps its verdict
        if (prot_load_in && idle) begin
            s_d.ro = prot_ro_in;
            s_d.xo = prot_xo_in;
        end
        // reads answered the next cycle, never stalled
        if (rd_req_in.valid) begin
            s_d.rd_valid = 1'b1;
            if (rd_allow) begin
                s_d.rd_data = mem_q[word_of(rd_req_in.addr)];
            end else begin
                s_d.rd_data = '0;
                s_d.rd_denied = 1'b1;
            end
        end
        case (s_q.state)
            ST_IDLE: begin
                if (mod_go) begin
                    if (!mod_allow) begin
                        s_d.mod_denied = 1'b1;
                        s_d.mod_done = 1'b1;
                    end else if (mod_req_in.erase) begin
                        s_d.state = ST_ERASE;
                        s_d.er_base = word_of(mod_req_in.addr) & ~WW'(FEP_BLK_WORDS - 1);
                        s_d.er_idx = '0;
                    end else begin
                        s_d.mod_done = 1'b1;
                    end
                end
            end
            ST_ERASE: begin
                s_d.er_idx = s_q.er_idx + BW'(1);
                if (er_last) begin
                    s_d.state = ST_IDLE;
                    s_d.mod_done = 1'b1;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
        // sticky violation flag; a new violation beats the clear
        if (viol_clr_in) begin
            s_d.viol = 1'b0;
        end
        if (s_d.rd_denied || s_d.mod_denied) begin
            s_d.viol = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.ro <= {NUM_REGIONS{FEP_PROT_RESET}};
            s_q.xo <= {NUM_REGIONS{FEP_PROT_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    // array storage; program only clears bits, as real flash cells do
    always_ff @(posedge clk_in) begin
        if (s_q.state == ST_ERASE) begin
            mem_q[s_q.er_base | WW'(s_q.er_idx)] <= FEP_ERASED_WORD;
        end else if (mod_go && mod_allow && !mod_req_in.erase) begin
            mem_q[word_of(mod_req_in.addr)] <= mem_q[word_of(mod_req_in.addr)] & mod_req_in.data;
        end
    end

    assign rd_data_out = s_q.rd_data;
    assign rd_valid_out = s_q.rd_valid;
    assign rd_denied_out = s_q.rd_denied;
    assign mod_done_out = s_q.mod_done;
    assign mod_denied_out = s_q.mod_denied;
    assign viol_out = s_q.viol;
    assign prot_ro_out = s_q.ro;
    assign prot_xo_out = s_q.xo;
endmodule // fep_ctrl

// File: testbench/fep_ctrl_chk.sv
// port assertions for the flash controller
`timescale 1ns/1ps
module fep_ctrl_chk
    import fep_pkg::*;
#(
    parameter int NUM_REGIONS = FEP_NUM_REGIONS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire fep_rd_req_t rd_req_in,
    input wire logic [FEP_DATA_W-1:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic rd_denied_out,
    input wire fep_mod_req_t mod_req_in,
    input wire logic mod_ready_out,
    input wire logic mod_done_out,
    input wire logic mod_denied_out,
    input wire logic viol_clr_in,
    input wire logic viol_out,
    input wire logic [NUM_REGIONS-1:0] prot_ro_out,
    input wire logic [NUM_REGIONS-1:0] prot_xo_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // region picked by the bits above the 2 KB offset
    wire logic [5:0] rd_rgn = rd_req_in.addr[16:11];
    wire logic [5:0] md_rgn = mod_req_in.addr[16:11];
    wire logic rd_lock = prot_xo_out[rd_rgn] && rd_req_in.src != FEP_SRC_IFETCH;
    wire logic md_lock = prot_ro_out[md_rgn] || prot_xo_out[md_rgn];
    wire logic md_take = mod_req_in.valid && mod_ready_out;
    // erase is accepted, then busy for at least 8 cycles and done 257 cycles after acceptance
    sequence erase_take;
        md_take && mod_req_in.erase && !md_lock;
    endsequence
    sequence erase_run;
        !mod_ready_out [*8] ##249 mod_done_out;
    endsequence
    a_read_late: assert property (rd_req_in.valid |=> rd_valid_out)
        else $error("read answer late");
    a_read_extra: assert property (!rd_req_in.valid |=> !rd_valid_out)
        else $error("read answer unasked");
    a_xo_leak: assert property (rd_req_in.valid && rd_lock |=> rd_denied_out && rd_data_out == '0 && viol_out)
        else $error("locked read leaked");
    a_fetch_ok: assert property (rd_req_in.valid && rd_req_in.src == FEP_SRC_IFETCH |=> !rd_denied_out)
        else $error("fetch refused");
    a_mod_lock: assert property (md_take && md_lock |=> mod_done_out && mod_denied_out && viol_out)
        else $error("locked modify taken");
    a_prog_open: assert property (md_take && !mod_req_in.erase && !md_lock |=> mod_done_out && !mod_denied_out)
        else $error("open program refused");
    a_erase_len: assert property (erase_take |=> erase_run)
        else $error("erase length wrong");
    a_viol_hold: assert property (viol_out && !viol_clr_in |=> viol_out)
        else $error("violation flag lost");
endmodule // fep_ctrl_chk

bind fep_ctrl fep_ctrl_chk #(.NUM_REGIONS(NUM_REGIONS)) u_fep_ctrl_chk (.*);

// File: testbench/fep_cpu_model.sv
// requester model: fetch, data load, debugger and flash writer
`timescale 1ns/1ps
module fep_cpu_model
    import fep_pkg::*;
(
    input wire logic clk_in,
    output fep_rd_req_t rd_req_out,
    output fep_mod_req_t mod_req_out
);
    initial begin
        rd_req_out = '0;
        mod_req_out = '0;
    end
    // released buses carry inverted junk, except the read source, which keeps its last value
    task automatic rd(input fep_src_t src, input logic [16:0] addr);
        @(negedge clk_in);
        rd_req_out = '{valid: 1'b1, src: src, addr: addr};
        @(negedge clk_in);
        rd_req_out = '{valid: 1'b0, src: src, addr: ~addr};
    endtask
    task automatic wr(input logic erase, input logic [16:0] addr, input logic [31:0] data);
        @(negedge clk_in);
        mod_req_out = '{valid: 1'b1, erase: erase, addr: addr, data: data};
        @(negedge clk_in);
        mod_req_out = '{valid: 1'b0, erase: ~erase, addr: ~addr, data: ~data};
    endtask
endmodule // fep_cpu_model

// File: testbench/fep_ctrl_bench.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
module fep_ctrl_bench
    import fep_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic prot_load_in = 1'b0;
    logic viol_clr_in = 1'b0;
    logic [63:0] prot_ro_in = '0;
    logic [63:0] prot_xo_in = '0;
    logic [63:0] prot_ro_out, prot_xo_out;
    logic [31:0] rd_data_out;
    logic rd_valid_out, rd_denied_out, mod_ready_out, mod_done_out, mod_denied_out, viol_out;
    fep_rd_req_t rd_req_in;
    fep_mod_req_t mod_req_in;
    int error_cnt = 0;
    int num_checks = 0;
    initial forever #20 clk_in = ~clk_in;
    fep_ctrl u_fep_ctrl (.*);
    fep_cpu_model u_fep_cpu_model (.clk_in, .rd_req_out(rd_req_in), .mod_req_out(mod_req_in));
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // answer stands one cycle, looked at on the next falling edge
    task automatic rd_chk(input fep_src_t src, input logic [16:0] addr, input logic [31:0] exp, input logic den);
        u_fep_cpu_model.rd(src, addr);
        chk("rd_valid", 32'(rd_valid_out), 32'h1);
        chk("rd_denied", 32'(rd_denied_out), 32'(den));
        chk("rd_data", rd_data_out, exp);
    endtask
    // erase takes 257 cycles, so the wait is bounded at 300
    task automatic mod_chk(input logic erase, input logic [16:0] addr, input logic [31:0] data, input logic den);
        int n;
        n = 0;
        u_fep_cpu_model.wr(erase, addr, data);
        while (mod_done_out !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        chk("mod_done", 32'(mod_done_out), 32'h1);
        chk("mod_denied", 32'(mod_denied_out), 32'(den));
        if (n == 300) end_sim();
    endtask
    task automatic t_erase();
        mod_chk(1'b1, 17'h00000, 32'h0, 1'b0);
        mod_chk(1'b1, 17'h00400, 32'h0, 1'b0);
        mod_chk(1'b0, 17'h00404, 32'h12345678, 1'b0);
        mod_chk(1'b1, 17'h00000, 32'h0, 1'b0);
        rd_chk(FEP_SRC_DLOAD, 17'h00404, 32'h12345678, 1'b0);
        rd_chk(FEP_SRC_DEBUG, 17'h003FC, 32'hFFFFFFFF, 1'b0);
        mod_chk(1'b1, 17'h1FC00, 32'h0, 1'b0);
        rd_chk(FEP_SRC_DLOAD, 17'h1FFFC, 32'hFFFFFFFF, 1'b0);
    endtask
    // region 0 read-only, region 63 execute-only, region 1 open
    task automatic t_prot();
        prot_ro_in = 64'h1;
        prot_xo_in = 64'h8000000000000000;
        prot_load_in = 1'b1;
        @(negedge clk_in);
        prot_load_in = 1'b0;
        chk("prot_ro", prot_ro_out[31:0], 32'h1);
        chk("prot_xo", prot_xo_out[63:32], 32'h80000000);
        mod_chk(1'b0, 17'h00404, 32'h0, 1'b1);
        mod_chk(1'b1, 17'h00000, 32'h0, 1'b1);
        rd_chk(FEP_SRC_DEBUG, 17'h00404, 32'h12345678, 1'b0);
        mod_chk(1'b1, 17'h1F800, 32'h0, 1'b1);
        rd_chk(FEP_SRC_IFETCH, 17'h1FFFC, 32'hFFFFFFFF, 1'b0);
        rd_chk(FEP_SRC_DLOAD, 17'h1FFFC, 32'h0, 1'b1);
        rd_chk(FEP_SRC_DEBUG, 17'h1F800, 32'h0, 1'b1);
        chk("viol", 32'(viol_out), 32'h1);
        viol_clr_in = 1'b1;
        @(negedge clk_in);
        viol_clr_in = 1'b0;
        chk("viol_clr", 32'(viol_out), 32'h0);
        mod_chk(1'b1, 17'h00800, 32'h0, 1'b0);
        rd_chk(FEP_SRC_DLOAD, 17'h00BFC, 32'hFFFFFFFF, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        chk("ro_reset", prot_ro_out[31:0] | prot_ro_out[63:32], 32'h0);
        chk("ready_reset", 32'(mod_ready_out), 32'h1);
        t_erase();
        t_prot();
        end_sim();
    end
endmodule // fep_ctrl_bench
